// >>> pkg/crbc_pkg.sv
package crbc_pkg;

  // ------------------------------------------------------------------
  // strap decoding
  // ------------------------------------------------------------------
  localparam logic STRAP_HS_ACTIVE = 1'h0;
  localparam logic [1:0] BUS_SPEED_HALF = 2'h2;
  localparam logic [1:0] PLLM_X2 = 2'h1;
  localparam logic [1:0] PLLM_X16 = 2'h3;
  localparam logic [4:0] MULT_X2 = 5'h02;
  localparam logic [4:0] MULT_X16 = 5'h10;
  localparam logic [4:0] MULT_NONE = 5'h00;

  // ------------------------------------------------------------------
  // clock divider and timing
  // ------------------------------------------------------------------
  localparam logic [1:0] DIV_FULL_LAST = 2'h0;
  localparam logic [1:0] DIV_HALF_LAST = 2'h1;
  localparam logic [1:0] DIV_ZERO = 2'h0;
  localparam int RST_MIN_CYCLES = 512;

  // ------------------------------------------------------------------
  // bus and timer
  // ------------------------------------------------------------------
  localparam int LANE_W = 16;
  localparam logic [1:0] TMR_MODE_PULSE_GEN = 2'h1;
  localparam logic TMR_IDLE_LEVEL = 1'h1;

  typedef struct packed {
    logic half_speed_strap_n;
    logic [1:0] bus_speed_strap;
    logic [1:0] pll_multiplier_strap;
  } crbc_strap_t;

  localparam crbc_strap_t STRAP_RESET = '{1'h1, 2'h0, 2'h3};

  typedef enum logic [1:0] {
    ST_RESET,
    ST_WAIT_CLK,
    ST_RUN
  } crbc_state_t;

endpackage

// >>> src/crbc_top.sv
`timescale 1ns/1ps
module crbc_top
  import crbc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int N_CHAN = 8,
  parameter int CHAN_W = 3,
  parameter int N_TMR = 2
) (
  input wire logic clk_in, // core clock
  input wire logic nrst_in, // async reset, active low
  input wire crbc_strap_t strap_in, // boot straps on address pins
  input wire logic clock_generator_enable_in, // clock generator enable
  input wire logic pll_lock_in, // pll locked
  output logic system_clock_out, // divided system clock
  output logic sys_rst_n_out, // internal reset, active low
  output logic half_speed_out, // half speed mode active
  output logic [4:0] pll_mult_out, // pll multiplier, 0 if illegal
  output logic xtal_allowed_out, // crystal may be used
  output logic strap_error_out, // illegal multiplier strap
  input wire logic ack_internal_mode_in, // internal acknowledge mode
  input wire logic [N_CHAN-1:0] chan_ready_sel_in, // ready mode per channel
  input wire logic [CHAN_W-1:0] chan_in, // channel of current access
  input wire logic bus_busy_in, // bus operation in progress
  input wire logic bus_done_internal_in, // internal termination pulse
  input wire logic ack_n_in, // acknowledge pin level
  output logic ack_n_out, // acknowledge pin drive value
  output logic ack_oe_n_out, // acknowledge pin enable, low drives
  output logic bus_end_out, // bus operation ended pulse
  output logic bus_wait_out, // access extended by ready
  input wire logic bus16_mode_in, // 16-bit bus mode
  input wire logic data_drive_in, // write data phase
  input wire logic [DATA_W-1:0] wdata_in, // write data
  input wire logic [DATA_W-1:0] data_in, // data pin levels
  output logic [DATA_W-1:0] data_out, // data pin drive values
  output logic [DATA_W-1:0] data_oe_n_out, // data pin enables, low drives
  output logic [DATA_W-1:0] rdata_out, // captured read data
  input wire logic [N_TMR*2-1:0] timer_mode_in, // mode per timer
  input wire logic [N_TMR-1:0] timer_wave_in, // generated waveform
  output logic [N_TMR-1:0] timer_out // timer pins
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  crbc_state_t st_r, st_nxt;
  crbc_strap_t strap_r, strap_nxt;
  logic [1:0] div_r, div_nxt;
  logic sclk_r, sclk_nxt;
  logic srst_r, srst_nxt;
  logic half_r, half_nxt;
  logic [4:0] mult_r, mult_nxt;
  logic xtal_r, xtal_nxt;
  logic serr_r, serr_nxt;
  logic ready_sel;
  logic ack_r, ack_nxt;
  logic ackoe_r, ackoe_nxt;
  logic end_r, end_nxt;
  logic wait_r, wait_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic [DATA_W-1:0] doe_r, doe_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  logic [N_TMR-1:0] tmr_r, tmr_nxt;
  logic [1:0] div_last;

  assign ready_sel = chan_ready_sel_in[chan_in];

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    strap_nxt = strap_r;
    unique case (st_r)
      ST_RESET: begin
        strap_nxt = strap_in;
        st_nxt = ST_WAIT_CLK;
      end
      ST_WAIT_CLK: begin
        if (clock_generator_enable_in && pll_lock_in) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!clock_generator_enable_in || !pll_lock_in) begin
          st_nxt = ST_WAIT_CLK;
        end
      end
    endcase

    half_nxt = (strap_nxt.half_speed_strap_n == STRAP_HS_ACTIVE) ||
               (strap_nxt.bus_speed_strap == BUS_SPEED_HALF);
    unique case (strap_nxt.pll_multiplier_strap)
      PLLM_X2: begin
        mult_nxt = MULT_X2;
        xtal_nxt = 1'h0;
        serr_nxt = 1'h0;
      end
      PLLM_X16: begin
        mult_nxt = MULT_X16;
        xtal_nxt = 1'h1;
        serr_nxt = 1'h0;
      end
      default: begin
        mult_nxt = MULT_NONE;
        xtal_nxt = 1'h0;
        serr_nxt = 1'h1;
      end
    endcase

    div_last = half_r ? DIV_HALF_LAST : DIV_FULL_LAST;
    if (st_r != ST_RUN) begin
      div_nxt = DIV_ZERO;
      sclk_nxt = 1'h0;
      srst_nxt = 1'h0;
    end else if (div_r == div_last) begin
      div_nxt = DIV_ZERO;
      sclk_nxt = ~sclk_r;
      srst_nxt = 1'h1;
    end else begin
      div_nxt = div_r + 2'h1;
      sclk_nxt = sclk_r;
      srst_nxt = 1'h1;
    end

    ack_nxt = 1'h1;
    ackoe_nxt = 1'h1;
    end_nxt = 1'h0;
    wait_nxt = 1'h0;
    if (ack_internal_mode_in) begin
      ackoe_nxt = 1'h0;
      ack_nxt = ~(bus_busy_in && bus_done_internal_in);
      end_nxt = bus_busy_in && bus_done_internal_in;
    end else if (ready_sel) begin
      wait_nxt = bus_busy_in && ack_n_in;
      end_nxt = bus_busy_in && bus_done_internal_in && !ack_n_in;
    end else begin
      end_nxt = bus_busy_in && !ack_n_in;
    end

    if (bus16_mode_in) begin
      dout_nxt = {{(DATA_W-LANE_W){1'h0}}, wdata_in[LANE_W-1:0]};
      doe_nxt = {{(DATA_W-LANE_W){1'h1}}, {LANE_W{~data_drive_in}}};
      rd_nxt = {{(DATA_W-LANE_W){1'h0}}, data_in[LANE_W-1:0]};
    end else begin
      dout_nxt = wdata_in;
      doe_nxt = {DATA_W{~data_drive_in}};
      rd_nxt = data_in;
    end
  end

  // ------------------------------------------------------------------
  // timer pins
  // ------------------------------------------------------------------
  for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
    assign tmr_nxt[i] = (timer_mode_in[i*2 +: 2] == TMR_MODE_PULSE_GEN) ?
                        timer_wave_in[i] : TMR_IDLE_LEVEL;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= ST_RESET;
      strap_r <= STRAP_RESET;
      div_r <= DIV_ZERO;
      sclk_r <= 1'h0;
      srst_r <= 1'h0;
      half_r <= 1'h0;
      mult_r <= MULT_NONE;
      xtal_r <= 1'h0;
      serr_r <= 1'h0;
      ack_r <= 1'h1;
      ackoe_r <= 1'h1;
      end_r <= 1'h0;
      wait_r <= 1'h0;
      dout_r <= '0;
      doe_r <= '1;
      rd_r <= '0;
      tmr_r <= {N_TMR{TMR_IDLE_LEVEL}};
    end else begin
      st_r <= st_nxt;
      strap_r <= strap_nxt;
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
      srst_r <= srst_nxt;
      half_r <= half_nxt;
      mult_r <= mult_nxt;
      xtal_r <= xtal_nxt;
      serr_r <= serr_nxt;
      ack_r <= ack_nxt;
      ackoe_r <= ackoe_nxt;
      end_r <= end_nxt;
      wait_r <= wait_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      rd_r <= rd_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  assign system_clock_out = sclk_r;
  assign sys_rst_n_out = srst_r;
  assign half_speed_out = half_r;
  assign pll_mult_out = mult_r;
  assign xtal_allowed_out = xtal_r;
  assign strap_error_out = serr_r;
  assign ack_n_out = ack_r;
  assign ack_oe_n_out = ackoe_r;
  assign bus_end_out = end_r;
  assign bus_wait_out = wait_r;
  assign data_out = dout_r;
  assign data_oe_n_out = doe_r;
  assign rdata_out = rd_r;
  assign timer_out = tmr_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_SCLK_FULL: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (st_r == ST_RUN && !half_r) |=> (sclk_r != $past(sclk_r)))
    else $error("system clock not toggling every cycle in full speed");
  AST_SCLK_HALF: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (st_r == ST_RUN && half_r && $past(st_r) == ST_RUN && $changed(sclk_r))
    |=> $stable(sclk_r))
    else $error("system clock toggling too fast in half speed");
  AST_HALF_SEL: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (st_r != ST_RESET) |-> (half_r ==
      ((strap_r.half_speed_strap_n == STRAP_HS_ACTIVE) ||
       (strap_r.bus_speed_strap == BUS_SPEED_HALF))))
    else $error("speed mode does not follow straps");
  AST_STRAP_HOLD: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    ($past(st_r) != ST_RESET) |-> $stable(strap_r))
    else $error("straps changed after capture");
  AST_MULT_X2: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (st_r != ST_RESET && strap_r.pll_multiplier_strap == PLLM_X2)
    |-> (pll_mult_out == MULT_X2 && !xtal_allowed_out))
    else $error("times-2 multiplier not applied");
  AST_MULT_X16: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (st_r != ST_RESET && strap_r.pll_multiplier_strap == PLLM_X16)
    |-> (pll_mult_out == MULT_X16 && xtal_allowed_out))
    else $error("times-16 multiplier not applied");
  AST_EXT_END: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (!ack_internal_mode_in && !ready_sel && bus_busy_in && !ack_n_in)
    |=> (bus_end_out && ack_oe_n_out))
    else $error("external acknowledge did not end the operation");
  AST_RDY_WAIT: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (!ack_internal_mode_in && ready_sel && bus_busy_in && ack_n_in)
    |=> (bus_wait_out && !bus_end_out))
    else $error("ready input did not extend the access");
  AST_INT_ACK: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (ack_internal_mode_in && bus_busy_in && bus_done_internal_in)
    |=> (!ack_n_out && !ack_oe_n_out && bus_end_out))
    else $error("internal acknowledge not driven");
  AST_BUS16: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    bus16_mode_in |=> (&data_oe_n_out[DATA_W-1:LANE_W] &&
      data_out[DATA_W-1:LANE_W] == '0 && rdata_out[DATA_W-1:LANE_W] == '0))
    else $error("upper data lines used in 16-bit mode");
  AST_TMR_IDLE: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (timer_mode_in[1:0] != TMR_MODE_PULSE_GEN) |=> timer_out[0])
    else $error("timer output not at 1 outside pulse generator mode");
  AST_HOLD_OFF: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    (!clock_generator_enable_in || !pll_lock_in) |=> ##1
      (!system_clock_out && !sys_rst_n_out))
    else $error("clock or reset released before lock");

endmodule

// >>> sim/crbc_board_model.sv
`timescale 1ns/1ps
module crbc_board_model
  import crbc_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic nrst_in, // board reset, active low
  input wire logic go_in, // reference clock has settled
  input wire crbc_strap_t strap_sel_in, // chosen boot straps
  input wire logic ack_n_in, // device ack drive value
  input wire logic ack_oe_n_in, // device ack enable, low drives
  input wire logic ext_ack_in, // external device pulls ack low
  output logic enable_out, // clock generator enable
  output logic lock_out, // pll locked
  output crbc_strap_t strap_out, // address pin levels
  output logic ack_pin_out // resolved ack pin level
);
  logic lock_r = 1'h0;
  logic [1:0] boot_r;
  // enable rises only once the reference clock is stable
  assign enable_out = go_in;
  always @(posedge clk_in) begin
    lock_r <= go_in;
  end
  assign lock_out = lock_r;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_r <= 2'h0;
    end else begin
      boot_r <= {boot_r[0], 1'h1};
    end
  end
  // address pins carry other traffic once boot is over
  assign strap_out = boot_r[1] ? crbc_strap_t'(~strap_sel_in) : strap_sel_in;
  // device drive value wins while enabled, else pull-up wins unless an external part drives low
  assign ack_pin_out = !ack_oe_n_in ? ack_n_in : !ext_ack_in;
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb
  import crbc_pkg::*;
;
  typedef struct {int cyc; int sel; logic [31:0] e;
                  logic [31:0] m;} crbc_note_t;
  logic clk_in, nrst_in, go, ext_ack, pint, pack, en, lock, ack_pin;
  logic sclk, srst_n, half, xtal, serr, ack_n, ack_oe_n, bend, bwait;
  logic imode, busy, done, b16, ddrv;
  crbc_strap_t strap_sel, strap;
  logic [4:0] mult;
  logic [7:0] rsel;
  logic [2:0] chan;
  logic [31:0] wdata, dpin, dout, doe_n, rdata, ext_data, pw, poe;
  logic [3:0] tmode;
  logic [1:0] twave, tout;
  crbc_note_t q[$];
  crbc_note_t nt;
  int cyc_cnt, err_total, n_tests;
  assign dpin = (dout & ~doe_n) | (ext_data & doe_n);
  crbc_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .strap_in(strap),
    .clock_generator_enable_in(en), .pll_lock_in(lock),
    .system_clock_out(sclk), .sys_rst_n_out(srst_n), .half_speed_out(half),
    .pll_mult_out(mult), .xtal_allowed_out(xtal), .strap_error_out(serr),
    .ack_internal_mode_in(imode), .chan_ready_sel_in(rsel), .chan_in(chan),
    .bus_busy_in(busy), .bus_done_internal_in(done), .ack_n_in(ack_pin),
    .ack_n_out(ack_n), .ack_oe_n_out(ack_oe_n), .bus_end_out(bend),
    .bus_wait_out(bwait), .bus16_mode_in(b16), .data_drive_in(ddrv),
    .wdata_in(wdata), .data_in(dpin), .data_out(dout),
    .data_oe_n_out(doe_n), .rdata_out(rdata), .timer_mode_in(tmode),
    .timer_wave_in(twave), .timer_out(tout));
  crbc_board_model board (.clk_in(clk_in), .nrst_in(nrst_in), .go_in(go),
    .strap_sel_in(strap_sel), .ack_n_in(ack_n), .ack_oe_n_in(ack_oe_n),
    .ext_ack_in(ext_ack), .enable_out(en), .lock_out(lock),
    .strap_out(strap), .ack_pin_out(ack_pin));
  // ------------------------------------------------------------------
  // checking
  // ------------------------------------------------------------------
  task automatic push(input int d, input int s, input logic [31:0] e,
                      input logic [31:0] m);
    q.push_back('{cyc_cnt + 1 + d, s, e, m});
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if ((seen & nt.m) !== (exp & nt.m)) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp & nt.m, seen & nt.m);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    #1;
    cyc_cnt++;
    while (q.size() > 0 && q[0].cyc <= cyc_cnt) begin
      nt = q.pop_front();
      case (nt.sel)
        0: check("half_speed", 32'(half), nt.e);
        1: check("pll_mult", 32'(mult), nt.e);
        2: check("xtal_allowed", 32'(xtal), nt.e);
        3: check("system_clock", 32'(sclk), nt.e);
        4: check("sys_rst_n", 32'(srst_n), nt.e);
        5: check("bus_end", 32'(bend), nt.e);
        6: check("bus_wait", 32'(bwait), nt.e);
        7: check("ack_n", 32'(ack_n), nt.e);
        8: check("ack_oe_n", 32'(ack_oe_n), nt.e);
        9: check("data_out", dout, nt.e);
        10: check("data_oe_n", doe_n, nt.e);
        11: check("rdata", rdata, nt.e);
        12: check("timer", 32'(tout), nt.e);
        default: check("strap_error", 32'(serr), nt.e);
      endcase
    end
  end
  // ------------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------------
  task automatic run_strap(input crbc_strap_t s);
    logic hs;
    logic [7:0] pat;
    hs = !s.half_speed_strap_n || s.bus_speed_strap == BUS_SPEED_HALF;
    // half speed spends its first run cycle counting before the first rise
    pat = hs ? 8'h66 : 8'haa;
    @(posedge clk_in);
    nrst_in <= 1'h0;
    go <= 1'h0;
    strap_sel <= s;
    repeat (RST_MIN_CYCLES) @(posedge clk_in);
    nrst_in <= 1'h1;
    push(1, 0, 32'(hs), 32'h1);
    push(1, 1, (s.pll_multiplier_strap == PLLM_X16) ? 32'(MULT_X16) :
         32'(MULT_X2), 32'h1f);
    push(1, 2, 32'(s.pll_multiplier_strap == PLLM_X16), 32'h1);
    push(1, 13, 32'h0, 32'h1);
    push(1, 4, 32'h0, 32'h1);
    repeat (4) @(posedge clk_in);
    go <= 1'h1;
    push(2, 4, 32'h0, 32'h1);
    push(3, 4, 32'h1, 32'h1);
    for (int d = 0; d < 8; d++) begin
      push(3 + d, 3, 32'(pat[7-d]), 32'h1);
    end
    push(10, 0, 32'(hs), 32'h1);
    repeat (10) @(posedge clk_in);
    go <= 1'h0;
    push(2, 4, 32'h0, 32'h1);
    push(2, 3, 32'h0, 32'h1);
    repeat (3) @(posedge clk_in);
  endtask
  task automatic rand_bus(input logic md);
    logic [31:0] r;
    logic [7:0] s;
    logic [2:0] c;
    logic [3:0] tm;
    logic [1:0] tw;
    logic bz, dn, ea, h16, dd, rdy, lvl;
    logic [31:0] w, x, ed, eo, pin;
    for (int k = 0; k < 60; k++) begin
      @(posedge clk_in);
      r = $urandom;
      {s, c, bz, dn, ea, h16, dd, tm, tw} = r[21:0];
      {rsel, chan, busy, done, ext_ack, b16, ddrv, tmode, twave} <= r[21:0];
      imode <= md;
      w = $urandom;
      x = $urandom;
      wdata <= w;
      ext_data <= x;
      rdy = s[c];
      lvl = pint ? pack : !ea;
      push(1, 5, 32'(md ? bz & dn : rdy ? bz & dn & !lvl : bz & !lvl), 1);
      push(1, 6, 32'(!md & rdy & bz & lvl), 32'h1);
      push(1, 8, 32'(!md), 32'h1);
      if (md) push(1, 7, 32'(!(bz & dn)), 32'h1);
      ed = h16 ? {16'h0, w[15:0]} : w;
      eo = {h16 ? 16'hffff : {16{!dd}}, {16{!dd}}};
      // pins seen next edge: last cycle's drive merged with the far side
      pin = (pw & ~poe) | (x & poe);
      push(1, 9, ed, 32'hffffffff);
      push(1, 10, eo, 32'hffffffff);
      push(1, 11, h16 ? {16'h0, pin[15:0]} : pin, 32'hffffffff);
      pw = ed;
      poe = eo;
      push(1, 12, {30'h0, tm[3:2] == TMR_MODE_PULSE_GEN ? tw[1] : 1'h1,
           tm[1:0] == TMR_MODE_PULSE_GEN ? tw[0] : 1'h1}, 32'h3);
      pint = md;
      pack = !(bz & dn);
    end
    repeat (2) @(posedge clk_in);
  endtask
  initial begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    $display("[ERR] watchdog expired");
    tally_and_finish();
  end
  initial begin
    {nrst_in, go, ext_ack, imode, busy, done, b16, ddrv} <= 8'h0;
    {rsel, chan, tmode, twave} <= 17'h0;
    {wdata, ext_data} <= 64'h0;
    strap_sel <= STRAP_RESET;
    pint = 1'h0;
    pack = 1'h1;
    pw = 32'h0;
    poe = 32'hffffffff;
    void'($urandom(1));
    for (int i = 0; i < 16; i++) begin
      run_strap({i[3], i[2:1], i[0], 1'h1});
      $display("strap case %0d done", i);
    end
    rand_bus(1'h0);
    $display("external acknowledge test done");
    rand_bus(1'h1);
    $display("internal acknowledge test done");
    tally_and_finish();
  end
endmodule
